//--- hw/ccr_cfg.svh
/*
 * Offsets, field positions, reset values and masks of the chip control
 * register bank. Assumes inclusion by the bank itself and by its bench.
 */
`ifndef CCR_CFG_SVH
`define CCR_CFG_SVH

// word index on the bus is {bank, offset}; byte address is four times it
`define CCR_BANK_CHIP      8'h20
`define CCR_BANK_IND       8'h2a
`define CCR_BANK_PHY       8'h2d
`define CCR_OFF_ID         4'h0
`define CCR_OFF_LED        4'ha
`define CCR_OFF_IAC        4'h0
`define CCR_OFF_RSV1       4'h2
`define CCR_OFF_RSV2       4'h4
`define CCR_OFF_RSV3       4'h6
`define CCR_OFF_DLO        4'h8
`define CCR_OFF_DHI        4'ha
`define CCR_OFF_PHYC       4'h0

`define CCR_LED_RST        16'h0835
`define CCR_LED_MASK       16'hffff
`define CCR_LED_SEL_HI     15
`define CCR_LED_SEL_LO     9
`define CCR_IAC_RST        16'h0000
`define CCR_IAC_DIR        12
`define CCR_IAC_TBL_HI     11
`define CCR_IAC_TBL_LO     10
`define CCR_IAC_ADR_HI     9
`define CCR_TBL_MIB        2'h3
`define CCR_DATA_RST       16'h0000
`define CCR_PHYC_RST       16'h1020
`define CCR_PHYC_MASK      16'h7b3f
`define CCR_PHYC_RO0       16'h8480
`define CCR_PHYC_F100      13
`define CCR_PHYC_ANEN      12
`define CCR_PHYC_PDN       11
`define CCR_PHYC_ANRS      9
`define CCR_PHYC_FDPX      8
`define CCR_PHYC_XALG      5
`define CCR_PHYC_FMDIX     4
`define CCR_PHYC_DMDIX     3
`define CCR_PHYC_TXDIS     1
`define CCR_PHYC_LEDDIS    0

`endif

//--- hw/ccr_chip_ctrl.sv
/*
 * Chip control register bank: identity, led mode, indirect counter access
 * engine with its 1024-entry counter table, and port phy basic control.
 * Assumes a classic Wishbone master that holds its request until ack.
 */
// Function
// R1: a write to the indirect control register launches one table access
// R2: direction bit 12: one reads the selected entry, zero writes it
// R3: table select bits 11-10; only code 11 (counters) acts, others ignored
// R4: entry address bits 9-0 pick the counter accessed
// R5: data low register holds bits 15-0 of the indirect word
// R6: data high register holds bits 31-16 of the indirect word
// R7: identity register is read-only: family, part, revision, bit 0 zero
// R8: two-bit led mode (bits 15, 9) selects what the four leds show
// R9: with negotiation off, bit 13 forces 100 Mbps or 10 Mbps
// R10: bit 12 enables negotiation, resets to one
// R11: bit 11 powers the phy down
// R12: writing one to bit 9 restarts negotiation
// R13: bit 8 forces duplex when negotiation is off or failed
// R14: bit 5 picks the crossover algorithm, resets to one
// R15: bit 4 forces crossed pair assignment
// R16: bit 3 disables automatic crossover detection
// R17: bit 1 disables the transmitter
// R18: bit 0 disables the led outputs
// R19: bits 15, 10, 7 read zero and ignore writes
// R20: host loads data registers before a write, reads them after a read
`timescale 1ns/100ps
`include "ccr_cfg.svh"

module ccr_chip_ctrl #(
    parameter logic [7:0] FAMILY_CODE = 8'h5a, // arbitrary value
    parameter logic [3:0] PART_CODE   = 4'h3,  // arbitrary value
    parameter logic [2:0] REV_CODE    = 3'h2   // arbitrary value
) (
    input  wire logic                   core_clk_i,
    input  wire logic                   arst_n_i,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [13:0]            wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o,
    input  wire ccr_pkg::ccr_phy_stat_t phy_stat_i,
    output ccr_pkg::ccr_phy_ctrl_t      phy_ctrl_o,
    output logic                        port_led_0_o,
    output logic                        port_led_1_o,
    output logic                        port_led_2_o,
    output logic                        port_led_3_o
);

    localparam logic [15:0] ID_WORD = {FAMILY_CODE, PART_CODE, REV_CODE,
                                       1'b0};

    // word decode; byte-address bits 1:0 are don't-care
    function automatic logic hit(input logic [11:0] idx,
                                 input logic [7:0]  bank,
                                 input logic [3:0]  off);
        hit = (idx == {bank, off});
    endfunction : hit

    // byte-lane merge; only lanes 0 and 1 carry register bits
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  sel,
                                          input logic [15:0] mask);
        logic [15:0] lane;
        lane  = {{8{sel[1]}}, {8{sel[0]}}} & mask;
        merge = (old & ~lane) | (wd[15:0] & lane);
    endfunction : merge

    logic [31:0] mib_mem [1024];
    logic [31:0] mib_word;

    ccr_pkg::ccr_state_t st_reg;
    ccr_pkg::ccr_state_t st_next;

    logic        req;
    logic        wr_now;
    logic [11:0] widx;
    logic        sel_id;
    logic        sel_led;
    logic        sel_iac;
    logic        sel_rsv;
    logic        sel_dlo;
    logic        sel_dhi;
    logic        sel_phyc;
    logic [15:0] iac_new;
    logic        mib_we;
    logic [9:0]  mib_waddr;
    logic [1:0]  led_mode;
    logic        link_act;

    assign req      = wb_cyc_i && wb_stb_i;
    // write takes effect at the edge where the master sees ack
    assign wr_now   = req && wb_we_i && st_reg.ack;
    assign widx     = wb_adr_i[13:2];
    assign sel_id   = hit(widx, `CCR_BANK_CHIP, `CCR_OFF_ID);
    assign sel_led  = hit(widx, `CCR_BANK_CHIP, `CCR_OFF_LED);
    assign sel_iac  = hit(widx, `CCR_BANK_IND, `CCR_OFF_IAC);
    assign sel_rsv  = hit(widx, `CCR_BANK_IND, `CCR_OFF_RSV1)
                      || hit(widx, `CCR_BANK_IND, `CCR_OFF_RSV2)
                      || hit(widx, `CCR_BANK_IND, `CCR_OFF_RSV3);
    assign sel_dlo  = hit(widx, `CCR_BANK_IND, `CCR_OFF_DLO);
    assign sel_dhi  = hit(widx, `CCR_BANK_IND, `CCR_OFF_DHI);
    assign sel_phyc = hit(widx, `CCR_BANK_PHY, `CCR_OFF_PHYC);
    assign iac_new  = merge(st_reg.iac, wb_dat_i, wb_sel_i, 16'hffff);

    // counter write uses the freshly written command word
    assign mib_we    = wr_now && sel_iac && !iac_new[`CCR_IAC_DIR]
                       && (iac_new[`CCR_IAC_TBL_HI:`CCR_IAC_TBL_LO]
                           == `CCR_TBL_MIB);                  // [R1] [R2] [R3]
    assign mib_waddr = iac_new[`CCR_IAC_ADR_HI:0];            // [R4]
    assign mib_word  = mib_mem[st_reg.iac[`CCR_IAC_ADR_HI:0]]; // [R4]

    always_ff @(posedge core_clk_i) begin
        if (mib_we) begin
            mib_mem[mib_waddr] <= {st_reg.dhi, st_reg.dlo}; // [R5] [R6]
        end
    end

    assign led_mode = {st_reg.led_ctl[`CCR_LED_SEL_HI],
                       st_reg.led_ctl[`CCR_LED_SEL_LO]};
    // activity blanks the link lamp in led modes 00 and 01, which makes it blink under traffic
    assign link_act = phy_stat_i.link_up && !phy_stat_i.activity;

    always_comb begin
        st_next = st_reg;
        // registered ack: one wait state, dropped right after
        st_next.ack = req && !st_reg.ack;
        st_next.phy.an_restart = 1'b0;
        st_next.rd_pend = 1'b0;
        if (req && !st_reg.ack && !wb_we_i) begin
            st_next.rdata = 32'h0000_0000;
            if (sel_id) begin
                st_next.rdata[15:0] = ID_WORD;                // [R7]
            end else if (sel_led) begin
                st_next.rdata[15:0] = st_reg.led_ctl;
            end else if (sel_iac) begin
                st_next.rdata[15:0] = st_reg.iac;
            end else if (sel_rsv) begin
                // reserved data registers stay zero, writes are dropped
                st_next.rdata[15:0] = 16'h0000;
            end else if (sel_dlo) begin
                st_next.rdata[15:0] = st_reg.dlo;             // [R5]
            end else if (sel_dhi) begin
                st_next.rdata[15:0] = st_reg.dhi;             // [R6]
            end else if (sel_phyc) begin
                st_next.rdata[15:0] = st_reg.phyc;
            end
        end
        if (wr_now) begin
            if (sel_led) begin
                st_next.led_ctl = merge(st_reg.led_ctl, wb_dat_i, wb_sel_i,
                                        `CCR_LED_MASK);
            end
            if (sel_iac) begin
                st_next.iac = iac_new;
                st_next.rd_pend = iac_new[`CCR_IAC_DIR]
                    && (iac_new[`CCR_IAC_TBL_HI:`CCR_IAC_TBL_LO]
                        == `CCR_TBL_MIB);                     // [R1] [R2] [R3]
            end
            if (sel_dlo) begin
                st_next.dlo = merge(st_reg.dlo, wb_dat_i, wb_sel_i, 16'hffff);
            end
            if (sel_dhi) begin
                st_next.dhi = merge(st_reg.dhi, wb_dat_i, wb_sel_i, 16'hffff);
            end
            if (sel_phyc) begin
                st_next.phyc = merge(st_reg.phyc, wb_dat_i, wb_sel_i,
                                     `CCR_PHYC_MASK);         // [R19]
                st_next.phy.an_restart = wb_sel_i[1]
                    && wb_dat_i[`CCR_PHYC_ANRS];              // [R12]
            end
        end
        // read result lands one edge after the command
        if (st_reg.rd_pend) begin
            st_next.dlo = mib_word[15:0];                     // [R5]
            st_next.dhi = mib_word[31:16];                    // [R6]
        end
        st_next.phy.an_enable  = st_reg.phyc[`CCR_PHYC_ANEN];  // [R10]
        st_next.phy.speed_100  = st_reg.phyc[`CCR_PHYC_ANEN]
            ? phy_stat_i.an_speed_100
            : st_reg.phyc[`CCR_PHYC_F100];                    // [R9]
        st_next.phy.full_duplex =
            (st_reg.phyc[`CCR_PHYC_ANEN] && !phy_stat_i.an_fail)
            ? phy_stat_i.an_full_duplex
            : st_reg.phyc[`CCR_PHYC_FDPX];                    // [R13]
        st_next.phy.power_down = st_reg.phyc[`CCR_PHYC_PDN];   // [R11]
        st_next.phy.crossover_algorithm_select =
            st_reg.phyc[`CCR_PHYC_XALG];                      // [R14]
        st_next.phy.force_mdix   = st_reg.phyc[`CCR_PHYC_FMDIX]; // [R15]
        st_next.phy.mdix_disable = st_reg.phyc[`CCR_PHYC_DMDIX]; // [R16]
        st_next.phy.tx_disable   = st_reg.phyc[`CCR_PHYC_TXDIS]; // [R17]
        unique case (led_mode)                                // [R8]
            2'b00: st_next.leds = {1'b0, link_act,
                                   st_reg.phy.full_duplex
                                   || phy_stat_i.collision,
                                   st_reg.phy.speed_100};
            2'b01: st_next.leds = {1'b0,
                                   link_act && st_reg.phy.speed_100,
                                   link_act && !st_reg.phy.speed_100,
                                   st_reg.phy.full_duplex};
            2'b10: st_next.leds = {phy_stat_i.activity,
                                   phy_stat_i.link_up,
                                   st_reg.phy.full_duplex
                                   || phy_stat_i.collision,
                                   st_reg.phy.speed_100};
            2'b11: st_next.leds = 4'h0;
        endcase
        if (st_reg.phyc[`CCR_PHYC_LEDDIS]) begin
            st_next.leds = 4'h0;                              // [R18]
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg <= '{ack: 1'b0, rdata: 32'h0000_0000,
                        led_ctl: `CCR_LED_RST, iac: `CCR_IAC_RST,
                        dlo: `CCR_DATA_RST, dhi: `CCR_DATA_RST,
                        phyc: `CCR_PHYC_RST, rd_pend: 1'b0, leds: 4'h0,
                        phy: '{an_enable: 1'b1,
                               crossover_algorithm_select: 1'b1,
                               default: 1'b0}};               // [R10] [R14]
        end else begin
            st_reg <= st_next;
        end
    end

    assign wb_ack_o     = st_reg.ack;
    assign wb_dat_o     = st_reg.rdata;
    assign phy_ctrl_o   = st_reg.phy;
    assign port_led_0_o = st_reg.leds[0];
    assign port_led_1_o = st_reg.leds[1];
    assign port_led_2_o = st_reg.leds[2];
    assign port_led_3_o = st_reg.leds[3];

    sequence s_cmd_accept;
        wr_now && sel_iac;
    endsequence

    sequence s_read_cmd;
        s_cmd_accept ##0 iac_new[`CCR_IAC_DIR]
        ##0 (iac_new[11:10] == 2'h3);
    endsequence

    chk_read_launch: assert property (                        // [R1] [R2]
        @(posedge core_clk_i) disable iff (!arst_n_i)
        s_read_cmd |=> st_reg.rd_pend ##1 !st_reg.rd_pend)
        else $error("read command did not launch once");

    chk_write_launch: assert property (                       // [R2] [R4]
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (s_cmd_accept ##0 !iac_new[`CCR_IAC_DIR]
         ##0 (iac_new[11:10] == 2'h3))
        |-> mib_we && (mib_waddr == wb_dat_i[9:0]))
        else $error("write command did not reach the table");

    chk_rsvd_table: assert property (                         // [R3]
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (s_cmd_accept ##0 (iac_new[11:10] != 2'h3))
        |-> !mib_we ##1 !st_reg.rd_pend)
        else $error("reserved table code caused an access");

    chk_read_data: assert property (                          // [R5] [R6]
        @(posedge core_clk_i) disable iff (!arst_n_i)
        st_reg.rd_pend |=> ({st_reg.dhi, st_reg.dlo} == $past(mib_word)))
        else $error("read result not split over data registers");

    chk_id_read: assert property (                            // [R7]
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (req && !st_reg.ack && !wb_we_i && sel_id)
        |=> wb_ack_o && (wb_dat_o == {16'h0000, ID_WORD}))
        else $error("identity read returned wrong word");

    chk_led_off: assert property (                            // [R8] [R18]
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (st_reg.phyc[0] || (led_mode == 2'b11)) |=> (st_reg.leds == 4'h0))
        else $error("leds lit while disabled or undefined mode");

    chk_forced_speed: assert property (                       // [R9] [R10]
        @(posedge core_clk_i) disable iff (!arst_n_i)
        !st_reg.phyc[12] |=> (phy_ctrl_o.speed_100 == $past(st_reg.phyc[13]))
                             && !phy_ctrl_o.an_enable)
        else $error("forced speed not applied");

    chk_forced_dpx: assert property (                         // [R13]
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (!st_reg.phyc[12] || phy_stat_i.an_fail)
        |=> (phy_ctrl_o.full_duplex == $past(st_reg.phyc[8])))
        else $error("forced duplex not applied");

    chk_an_restart: assert property (                         // [R12]
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (wr_now && sel_phyc && wb_sel_i[1] && wb_dat_i[9])
        |=> phy_ctrl_o.an_restart ##1 !phy_ctrl_o.an_restart)
        else $error("restart pulse missing or too long");

    chk_ro_bits: assert property (                            // [R19]
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (st_reg.phyc & `CCR_PHYC_RO0) == 16'h0000)
        else $error("unsupported control bits became set");

    chk_bus_ack: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (req && !st_reg.ack) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse after one wait");

    chk_rsvd_read: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (req && !st_reg.ack && !wb_we_i && sel_rsv)
        |=> wb_ack_o && (wb_dat_o == 32'h0000_0000))
        else $error("reserved data register read not zero");

    chk_table_write: assert property (                        // [R5] [R6]
        @(posedge core_clk_i) disable iff (!arst_n_i)
        mib_we |=> (mib_mem[$past(mib_waddr)]
                    == {$past(st_reg.dhi), $past(st_reg.dlo)}))
        else $error("table entry not loaded from data registers");

    chk_neg_result: assert property (                         // [R10]
        @(posedge core_clk_i) disable iff (!arst_n_i)
        st_reg.phyc[`CCR_PHYC_ANEN]
        |=> phy_ctrl_o.an_enable
            && (phy_ctrl_o.speed_100 == $past(phy_stat_i.an_speed_100)))
        else $error("negotiated speed not followed");

    chk_phy_levels: assert property (   // [R11] [R14] [R15] [R16] [R17]
        @(posedge core_clk_i) disable iff (!arst_n_i)
        1'b1 |=> ({phy_ctrl_o.power_down,
                   phy_ctrl_o.crossover_algorithm_select,
                   phy_ctrl_o.force_mdix, phy_ctrl_o.mdix_disable,
                   phy_ctrl_o.tx_disable}
                  == $past({st_reg.phyc[`CCR_PHYC_PDN],
                            st_reg.phyc[`CCR_PHYC_XALG],
                            st_reg.phyc[`CCR_PHYC_FMDIX],
                            st_reg.phyc[`CCR_PHYC_DMDIX],
                            st_reg.phyc[`CCR_PHYC_TXDIS]})))
        else $error("phy control level does not follow its bit");

    chk_led_mode: assert property (                           // [R8]
        @(posedge core_clk_i) disable iff (!arst_n_i)
        ((led_mode == 2'b10) && !st_reg.phyc[`CCR_PHYC_LEDDIS])
        |=> (st_reg.leds[3:2]
             == $past({phy_stat_i.activity, phy_stat_i.link_up})))
        else $error("mode 10 lamps do not show activity and link");

    chk_phyc_write: assert property (                         // [R19]
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (wr_now && sel_phyc && (wb_sel_i[1:0] == 2'h3))
        |=> (st_reg.phyc == ($past(wb_dat_i[15:0]) & `CCR_PHYC_MASK)))
        else $error("phy control write not masked as expected");

endmodule : ccr_chip_ctrl

//--- hw/ccr_pkg.sv
/*
 * Types of the chip control register bank.
 * Assumes ccr_cfg.svh is on the include path.
 */
package ccr_pkg;

    typedef struct packed {
        logic speed_100;       // resolved line speed
        logic full_duplex;     // resolved duplex
        logic an_enable;
        logic an_restart;      // one-cycle pulse
        logic power_down;
        logic crossover_algorithm_select;
        logic force_mdix;
        logic mdix_disable;
        logic tx_disable;
    } ccr_phy_ctrl_t;

    typedef struct packed {
        logic link_up;
        logic activity;
        logic collision;
        logic an_speed_100;    // negotiated result
        logic an_full_duplex;
        logic an_fail;
    } ccr_phy_stat_t;

    typedef struct packed {
        logic          ack;
        logic [31:0]   rdata;
        logic [15:0]   led_ctl;
        logic [15:0]   iac;
        logic [15:0]   dlo;
        logic [15:0]   dhi;
        logic [15:0]   phyc;
        logic          rd_pend;
        logic [3:0]    leds;
        ccr_phy_ctrl_t phy;
    } ccr_state_t;

endpackage : ccr_pkg

//--- test/ccr_chip_ctrl_tb.sv
/*
 * Self-checking bench of the chip control register bank.
 * Assumes ccr_cfg.svh on the include path and the phy model beside it.
 */
`timescale 1ns/100ps
`include "ccr_cfg.svh"

module ccr_chip_ctrl_tb;
    logic                   clk, rst_n, cyc, stb, we;
    logic [13:0]            adr;
    logic [3:0]             sel;
    logic [31:0]            wdat, rdat;
    logic                   ack;
    logic [5:0]             knob;
    wire  [3:0]             leds;
    ccr_pkg::ccr_phy_stat_t stat;
    ccr_pkg::ccr_phy_ctrl_t ctrl;
    int                     num_errors, total_checks, restarts;

    ccr_chip_ctrl u_ccr_chip_ctrl (
        .core_clk_i(clk), .arst_n_i(rst_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .phy_stat_i(stat), .phy_ctrl_o(ctrl), .port_led_0_o(leds[0]),
        .port_led_1_o(leds[1]), .port_led_2_o(leds[2]),
        .port_led_3_o(leds[3]));

    ccr_phy_model u_ccr_phy_model (
        .core_clk_i(clk), .arst_n_i(rst_n), .phy_ctrl_i(ctrl),
        .knob_i(knob), .phy_stat_o(stat));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        if (ctrl.an_restart === 1'b1) restarts++;
    end

    function automatic logic [13:0] ba(logic [7:0] b, logic [3:0] o);
        return {b, o, 2'b00};
    endfunction : ba

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // request stands until ack is sampled high at a rising edge
    task automatic xfer(logic w, logic [13:0] a, logic [15:0] d,
                        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h3;
        wdat <= {16'h0000, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) chk("bus ack", 32'h1, 32'h0);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : xfer

    task automatic wr(logic [13:0] a, logic [15:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(string what, logic [13:0] a, logic [15:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 16'h0000, q);
        chk(what, {16'h0000, e}, q);
    endtask : rd_chk

    task automatic settle();
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task automatic t_reset_values();
        logic [15:0] id;
        id = {8'h5a, 4'h3, 3'h2, 1'b0};
        settle();
        chk("ctrl at reset", 9'b1_1100_1000, ctrl);
        rd_chk("identity", ba(`CCR_BANK_CHIP, `CCR_OFF_ID), id);
        wr(ba(`CCR_BANK_CHIP, `CCR_OFF_ID), 16'hffff);
        rd_chk("identity ro", ba(`CCR_BANK_CHIP, `CCR_OFF_ID), id);
        rd_chk("led ctl", ba(`CCR_BANK_CHIP, `CCR_OFF_LED), 16'h0835);
        rd_chk("iac", ba(`CCR_BANK_IND, `CCR_OFF_IAC), 16'h0000);
        rd_chk("rsv1", ba(`CCR_BANK_IND, `CCR_OFF_RSV1), 16'h0000);
        wr(ba(`CCR_BANK_IND, `CCR_OFF_RSV3), 16'h1234);
        rd_chk("rsv3", ba(`CCR_BANK_IND, `CCR_OFF_RSV3), 16'h0000);
        rd_chk("phyc", ba(`CCR_BANK_PHY, `CCR_OFF_PHYC), 16'h1020);
        wr(ba(8'h21, 4'h0), 16'hbeef);
        rd_chk("unmapped", ba(8'h21, 4'h0), 16'h0000);
    endtask : t_reset_values

    // two entries at the ends of the address range, written then read back
    task automatic t_indirect();
        logic [9:0]  ea [2] = '{10'h000, 10'h3ff};
        logic [31:0] ev [2] = '{32'hcafe_1234, 32'h5a5a_a5a5};
        for (int i = 0; i < 2; i++) begin
            wr(ba(`CCR_BANK_IND, `CCR_OFF_DLO), ev[i][15:0]);
            wr(ba(`CCR_BANK_IND, `CCR_OFF_DHI), ev[i][31:16]);
            wr(ba(`CCR_BANK_IND, `CCR_OFF_IAC), {6'b000_011, ea[i]});
        end
        for (int i = 0; i < 2; i++) begin
            wr(ba(`CCR_BANK_IND, `CCR_OFF_DLO), 16'h0000);
            wr(ba(`CCR_BANK_IND, `CCR_OFF_DHI), 16'h0000);
            wr(ba(`CCR_BANK_IND, `CCR_OFF_IAC), {6'b000_111, ea[i]});
            rd_chk("data lo", ba(`CCR_BANK_IND, `CCR_OFF_DLO),
                   ev[i][15:0]);
            rd_chk("data hi", ba(`CCR_BANK_IND, `CCR_OFF_DHI),
                   ev[i][31:16]);
        end
        // undefined table code leaves the data registers alone
        wr(ba(`CCR_BANK_IND, `CCR_OFF_IAC), {6'b000_110, 10'h000});
        rd_chk("tbl2 lo", ba(`CCR_BANK_IND, `CCR_OFF_DLO), 16'ha5a5);
        rd_chk("iac store", ba(`CCR_BANK_IND, `CCR_OFF_IAC), 16'h1800);
    endtask : t_indirect

    task automatic t_phy_ctrl();
        knob <= 6'b100_001;
        wr(ba(`CCR_BANK_PHY, `CCR_OFF_PHYC), 16'hffff);
        rd_chk("phyc ro", ba(`CCR_BANK_PHY, `CCR_OFF_PHYC), 16'h7b3f);
        settle();
        chk("ctrl all set", 9'b0_1101_1111, ctrl);
        chk("restart once", 1, restarts);
        wr(ba(`CCR_BANK_PHY, `CCR_OFF_PHYC), 16'h2100);
        settle();
        chk("forced 100 full", 9'b1_1000_0000, ctrl);
        wr(ba(`CCR_BANK_PHY, `CCR_OFF_PHYC), 16'h0018);
        settle();
        chk("forced 10 half", 9'b0_0000_0110, ctrl);
        knob <= 6'b000_110;
        wr(ba(`CCR_BANK_PHY, `CCR_OFF_PHYC), 16'h1220);
        settle();
        chk("negotiated", 9'b1_1100_1000, ctrl);
        chk("restart twice", 2, restarts);
    endtask : t_phy_ctrl

    // 10 Mbps full duplex, link up and idle
    task automatic t_leds();
        logic [3:0]  el [4] = '{4'b0110, 4'b0011, 4'b0110, 4'b0000};
        logic [15:0] mv [4] = '{16'h0835, 16'h0a35, 16'h8835, 16'h8a35};
        knob <= 6'b100_000;
        wr(ba(`CCR_BANK_PHY, `CCR_OFF_PHYC), 16'h0100);
        for (int m = 0; m < 4; m++) begin
            wr(ba(`CCR_BANK_CHIP, `CCR_OFF_LED), mv[m]);
            settle();
            chk("leds per mode", el[m], leds);
        end
        // busy link: lamp 3 shows activity, link lamp blanks in mode 00
        knob <= 6'b110_000;
        wr(ba(`CCR_BANK_CHIP, `CCR_OFF_LED), mv[2]);
        settle();
        chk("leds mode 10 busy", 4'b1110, leds);
        wr(ba(`CCR_BANK_CHIP, `CCR_OFF_LED), mv[0]);
        settle();
        chk("leds mode 00 busy", 4'b0010, leds);
        wr(ba(`CCR_BANK_PHY, `CCR_OFF_PHYC), 16'h0101);
        settle();
        chk("leds disabled", 4'b0000, leds);
    endtask : t_leds

    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    // the scenarios need well under a thousand cycles
    initial begin
        #100_000;
        num_errors++;
        summarize();
    end

    initial begin
        num_errors = 0;
        total_checks = 0;
        restarts = 0;
        rst_n <= 1'b0;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        adr <= '0;
        sel <= '0;
        wdat <= '0;
        knob <= 6'b000_110;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_values();
        t_indirect();
        t_phy_ctrl();
        t_leds();
        summarize();
    end
endmodule : ccr_chip_ctrl_tb

//--- test/ccr_phy_model.sv
/*
 * Behavioural port phy seen from the register bank: reports link,
 * activity and negotiation status. Assumes the bench sets the raw
 * line state through knob_i, ordered as the status struct.
 */
`timescale 1ns/100ps

module ccr_phy_model (
    input  wire logic                   core_clk_i,
    input  wire logic                   arst_n_i,
    input  wire ccr_pkg::ccr_phy_ctrl_t phy_ctrl_i,
    input  wire logic [5:0]             knob_i,
    output ccr_pkg::ccr_phy_stat_t      phy_stat_o
);
    // registered, so the bank sees status one cycle late like a real phy
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            phy_stat_o <= '0;
        end else begin
            phy_stat_o <= knob_i;
            // a powered-down phy has no link
            if (phy_ctrl_i.power_down) begin
                phy_stat_o.link_up <= 1'b0;
            end
        end
    end
endmodule : ccr_phy_model
